// ---- logic/acfg_defines.svh ----
// register offsets, fields, reset values and counts of the configuration bank
`ifndef ACFG_DEFINES_SVH
`define ACFG_DEFINES_SVH

`define ACFG_ADDR_W            4
`define ACFG_ADDR_IDENT        4'h0
`define ACFG_ADDR_CONV         4'h1
`define ACFG_ADDR_INGAIN       4'h2
`define ACFG_ADDR_HPLO         4'h3
`define ACFG_ADDR_HPHI         4'h4

`define ACFG_RST_OFFSET        2'h0
`define ACFG_RST_CONV          8'h52
`define ACFG_RST_INGAIN        8'h08
`define ACFG_RST_HPLO          8'h32
`define ACFG_RST_HPHI          8'h03
`define ACFG_INGAIN_RW_MASK    8'h7f

`define ACFG_CONV_SYNC_BIT     7
`define ACFG_CONV_MODE_BIT     6
`define ACFG_CONV_RATE_HI      5
`define ACFG_CONV_RATE_LO      3
`define ACFG_CONV_PHASE_BIT    2
`define ACFG_CONV_FILT_HI      1
`define ACFG_CONV_FILT_LO      0
`define ACFG_INGAIN_ROUTE_HI   6
`define ACFG_INGAIN_ROUTE_LO   4
`define ACFG_INGAIN_AMP_CHOPPING_EN_BIT   3
`define ACFG_INGAIN_GAIN_HI    2
`define ACFG_INGAIN_GAIN_LO    0

`define ACFG_OFFSET_OFF        2'h0
`define ACFG_OFFSET_RSVD       2'h1
`define ACFG_OFFSET_HIGH       2'h2
`define ACFG_OFFSET_LOW        2'h3
`define ACFG_OFFSET_HIGH_MV    7'h64
`define ACFG_OFFSET_LOW_MV     7'h4b

`define ACFG_RATE_BASE_SPS     13'h0fa
`define ACFG_RATE_MAX_CODE     3'h4
`define ACFG_FILT_RSVD         2'h0
`define ACFG_ROUTE_MAX_CODE    3'h4
`define ACFG_GAIN_MAX_CODE     3'h6

`define ACFG_GAP_READINGS      6'h3f

`endif

// ---- logic/acfg_pkg.sv ----
// types shared by the configuration bank modules
package acfg_pkg;

    typedef enum logic [1:0] {
        ACFG_RUN    = 2'b01,
        ACFG_SETTLE = 2'b10
    } acfg_state_t;

    typedef logic [7:0] acfg_byte_t;

endpackage : acfg_pkg

// ---- logic/acfg_restart_if.sv ----
// restart handshake between register bank and gap counter
`timescale 1ns/1ns
interface acfg_restart_if;
    logic       restart;
    logic       reading_tick;
    logic       settled;
    logic [5:0] gap_left;

    modport bank (output restart, output reading_tick, input settled, input gap_left);
    modport gap  (input restart, input reading_tick, output settled, output gap_left);
endinterface : acfg_restart_if

// ---- logic/acfg_restart_gap.sv ----
// counts the readings lost after a pipeline restart
`timescale 1ns/1ns
`include "acfg_defines.svh"
module acfg_restart_gap (
    // clock and reset
    input wire logic     sys_clk,
    input wire logic     reset_n,
    // link to the bank
    acfg_restart_if.gap  rif
);
    import acfg_pkg::*;

    acfg_state_t state_reg;
    logic [5:0]  count_reg;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ACFG_RUN;
            count_reg <= 6'h00;
        end
        else
        begin
            unique case (state_reg)
                ACFG_RUN:
                begin
                    if (rif.restart)
                    begin
                        state_reg <= ACFG_SETTLE;
                        count_reg <= `ACFG_GAP_READINGS;
                    end
                end
                ACFG_SETTLE:
                begin
                    if (rif.restart)
                        count_reg <= `ACFG_GAP_READINGS;
                    else if (rif.reading_tick)
                    begin
                        count_reg <= count_reg - 6'h01;
                        if (count_reg == 6'h01)
                            state_reg <= ACFG_RUN;
                    end
                end
            endcase
        end
    end

    assign rif.settled  = (state_reg == ACFG_RUN);
    assign rif.gap_left = count_reg;
endmodule : acfg_restart_gap

// ---- logic/acfg_bank.sv ----
// configuration register bank of the converter
// How it works
// - offset code 01 is reserved, 10 gives 100 mV over gain and 11 gives 75 mV over gain.
// - converter_config at 01h resets to 52h; bit 7 picks continuous sync, bit 6 picks high resolution.
// - rate_sel in bits 5:3 picks 250, 500, 1000, 2000 or 4000 samples per second.
// - input_gain_config at 02h resets to 08h, bit 3 enables chopping, bit 7 is held at zero.
// - gain_sel in bits 2:0 sets gain to two to the power of the code for codes 0 to 6; code 7 gives zero.
// - hp_corner_low at 03h is read-write, resets to 32h and forms corner bits 7:0.
// - any write to addresses 00h to 04h restarts the pipeline and 63 readings are dropped; other addresses do not.
// - hp_corner_high at 04h resets to 03h and forms corner bits 15:8.
// - the offset code sits in bits 1:0 of address 00h and resets to 00.
`timescale 1ns/1ns
`include "acfg_defines.svh"
module acfg_bank #(
    parameter logic [3:0] IDENT_CODE = 4'h5 // arbitrary value
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    // register access port
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire logic [3:0]               reg_addr,
    input  wire acfg_pkg::acfg_byte_t     reg_wr_data,
    output acfg_pkg::acfg_byte_t          reg_rd_data,
    output logic                          reg_rd_valid,
    // datapath timing
    input  wire logic                     reading_tick,
    output logic                          data_valid,
    output logic                          pipeline_restart,
    // converter controls
    output logic                          sync_continuous,
    output logic                          high_res_mode,
    output logic [2:0]                    rate_sel,
    output logic [12:0]                   rate_sps,
    output logic                          fir_min_phase,
    output logic [1:0]                    filter_chain_sel,
    output logic                          hp_filter_en,
    output logic                          lp_filter_en,
    // input and gain controls
    output logic [2:0]                    input_route_sel,
    output logic                          amp_chopping_en,
    output logic [2:0]                    gain_sel,
    output logic [6:0]                    gain_value,
    output logic [15:0]                   hp_corner,
    // offset injection
    output logic [1:0]                    offset_sel,
    output logic                          offset_inject_en,
    output logic [6:0]                    offset_mv,
    output logic [2:0]                    offset_shift,
    // reserved code written
    output logic                          reserved_code
);
    import acfg_pkg::*;

    logic [1:0]  offset_reg;
    acfg_byte_t  conv_reg;
    acfg_byte_t  ingain_reg;
    acfg_byte_t  hplo_reg;
    acfg_byte_t  hphi_reg;
    acfg_byte_t  rd_next;
    logic        hit;
    logic        dv_reg;
    logic        rate_rsvd;
    logic        filt_rsvd;
    logic        route_rsvd;
    logic        gain_rsvd;
    logic        offset_rsvd;

    acfg_restart_if rif ();

    acfg_restart_gap u_gap (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .rif     (rif)
    );

    assign hit = (reg_addr <= `ACFG_ADDR_HPHI);

    // register writes
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            offset_reg <= `ACFG_RST_OFFSET;
            conv_reg   <= `ACFG_RST_CONV;
            ingain_reg <= `ACFG_RST_INGAIN;
            hplo_reg   <= `ACFG_RST_HPLO;
            hphi_reg   <= `ACFG_RST_HPHI;
        end
        else if (reg_wr_en)
        begin
            unique case (reg_addr)
                `ACFG_ADDR_IDENT:  offset_reg <= reg_wr_data[1:0];
                `ACFG_ADDR_CONV:   conv_reg   <= reg_wr_data;
                `ACFG_ADDR_INGAIN: ingain_reg <= reg_wr_data & `ACFG_INGAIN_RW_MASK;
                `ACFG_ADDR_HPLO:   hplo_reg   <= reg_wr_data;
                `ACFG_ADDR_HPHI:   hphi_reg   <= reg_wr_data;
                default:           ;
            endcase
        end
    end

    // restart on any mapped write
    assign rif.restart      = reg_wr_en && hit;
    assign rif.reading_tick = reading_tick;
    assign pipeline_restart = rif.restart;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            dv_reg <= 1'b1;
        else
            dv_reg <= rif.settled && !rif.restart;
    end
    assign data_valid = dv_reg;

    // read mux
    always_comb
    begin
        rd_next = 8'h00;
        unique case (reg_addr)
            `ACFG_ADDR_IDENT:  rd_next = {IDENT_CODE, 2'b00, offset_reg};
            `ACFG_ADDR_CONV:   rd_next = conv_reg;
            `ACFG_ADDR_INGAIN: rd_next = ingain_reg;
            `ACFG_ADDR_HPLO:   rd_next = hplo_reg;
            `ACFG_ADDR_HPHI:   rd_next = hphi_reg;
            default:           rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rd_data  <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
                reg_rd_data <= rd_next;
        end
    end

    // converter fields
    assign sync_continuous  = conv_reg[`ACFG_CONV_SYNC_BIT];
    assign high_res_mode    = conv_reg[`ACFG_CONV_MODE_BIT];
    assign rate_sel         = conv_reg[`ACFG_CONV_RATE_HI:`ACFG_CONV_RATE_LO];

    // output rate per code, unlisted codes give zero
    always_comb
    begin
        rate_sps = 13'h0000;
        unique case (rate_sel)
            3'h0:    rate_sps = `ACFG_RATE_BASE_SPS;
            3'h1:    rate_sps = `ACFG_RATE_BASE_SPS << 1;
            3'h2:    rate_sps = `ACFG_RATE_BASE_SPS << 2;
            3'h3:    rate_sps = `ACFG_RATE_BASE_SPS << 3;
            3'h4:    rate_sps = `ACFG_RATE_BASE_SPS << 4;
            default: rate_sps = 13'h0000;
        endcase
    end

    assign fir_min_phase    = conv_reg[`ACFG_CONV_PHASE_BIT];
    assign filter_chain_sel = conv_reg[`ACFG_CONV_FILT_HI:`ACFG_CONV_FILT_LO];
    assign lp_filter_en     = filter_chain_sel[1];
    assign hp_filter_en     = (filter_chain_sel == 2'b11);

    // input and gain fields
    assign input_route_sel  = ingain_reg[`ACFG_INGAIN_ROUTE_HI:`ACFG_INGAIN_ROUTE_LO];
    assign amp_chopping_en  = ingain_reg[`ACFG_INGAIN_AMP_CHOPPING_EN_BIT];
    assign gain_sel         = ingain_reg[`ACFG_INGAIN_GAIN_HI:`ACFG_INGAIN_GAIN_LO];

    // amplifier gain per code, unlisted code gives zero
    always_comb
    begin
        gain_value = 7'h00;
        unique case (gain_sel)
            3'h0:    gain_value = 7'h01;
            3'h1:    gain_value = 7'h02;
            3'h2:    gain_value = 7'h04;
            3'h3:    gain_value = 7'h08;
            3'h4:    gain_value = 7'h10;
            3'h5:    gain_value = 7'h20;
            3'h6:    gain_value = 7'h40;
            default: gain_value = 7'h00;
        endcase
    end

    assign hp_corner        = {hphi_reg, hplo_reg};

    // offset injection, magnitude is offset_mv >> offset_shift
    assign offset_sel       = offset_reg;
    assign offset_inject_en = (offset_reg == `ACFG_OFFSET_HIGH) || (offset_reg == `ACFG_OFFSET_LOW);

    // offset magnitude before the gain shift
    always_comb
    begin
        offset_mv = 7'h00;
        unique case (offset_reg)
            `ACFG_OFFSET_OFF:  offset_mv = 7'h00;
            `ACFG_OFFSET_RSVD: offset_mv = 7'h00;
            `ACFG_OFFSET_HIGH: offset_mv = `ACFG_OFFSET_HIGH_MV;
            `ACFG_OFFSET_LOW:  offset_mv = `ACFG_OFFSET_LOW_MV;
        endcase
    end

    assign offset_shift     = gain_sel;

    // unlisted codes, one flag per field
    assign rate_rsvd        = (rate_sel > `ACFG_RATE_MAX_CODE);
    assign filt_rsvd        = (filter_chain_sel == `ACFG_FILT_RSVD);
    assign route_rsvd       = (input_route_sel > `ACFG_ROUTE_MAX_CODE);
    assign gain_rsvd        = (gain_sel > `ACFG_GAIN_MAX_CODE);
    assign offset_rsvd      = (offset_reg == `ACFG_OFFSET_RSVD);
    assign reserved_code    = rate_rsvd || filt_rsvd || route_rsvd || gain_rsvd || offset_rsvd;
endmodule : acfg_bank

// ---- tb/acfg_bank_chk.sv ----
// port assertions for the configuration bank
`timescale 1ns/1ns
module acfg_bank_chk (
    // clock and reset
    input wire logic        sys_clk, reset_n,
    // register port and timing
    input wire logic        reg_wr_en, reg_rd_en, reg_rd_valid,
    input wire logic [3:0]  reg_addr,
    input wire logic        reading_tick, data_valid, pipeline_restart,
    // decoded fields
    input wire logic [2:0]  rate_sel, gain_sel, offset_shift,
    input wire logic [12:0] rate_sps,
    input wire logic [6:0]  gain_value, offset_mv,
    input wire logic [1:0]  filter_chain_sel, offset_sel,
    input wire logic        hp_filter_en, lp_filter_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_restart_mapped: assert property (pipeline_restart == (reg_wr_en && reg_addr <= 4'h4))
        else $error("restart not tied to mapped write");
    a_gap_start: assert property (pipeline_restart |=> !data_valid)
        else $error("data valid during gap");
    a_gap_hold: assert property (!data_valid && !reading_tick && !$past(reading_tick) && !$past(reading_tick, 2)
        |=> !data_valid)
        else $error("gap ended without reading");
    a_read_valid: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered");
    a_valid_cause: assert property ($rose(reg_rd_valid) |-> $past(reg_rd_en))
        else $error("read valid without request");
    a_rate_map: assert property (rate_sps == (rate_sel <= 3'h4 ? 13'h0fa << rate_sel : 13'h0))
        else $error("rate value wrong");
    a_gain_map: assert property (gain_value == (gain_sel <= 3'h6 ? 7'h1 << gain_sel : 7'h0))
        else $error("gain value wrong");
    a_offset_mv: assert property (offset_mv == (offset_sel == 2'h2 ? 7'h64 : offset_sel == 2'h3 ? 7'h4b : 7'h0))
        else $error("offset value wrong");
    a_offset_shift: assert property (offset_shift == gain_sel)
        else $error("offset not scaled by gain");
    a_filter_en: assert property (hp_filter_en == (filter_chain_sel == 2'h3) && lp_filter_en == filter_chain_sel[1])
        else $error("filter enables wrong");
endmodule : acfg_bank_chk
bind acfg_bank acfg_bank_chk u_chk (.*);

// ---- tb/acfg_tick_src.sv ----
// datapath model: one reading every four clocks while enabled
`timescale 1ns/1ns
module acfg_tick_src (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic en,
    output logic     reading_tick
);
    logic [1:0] cnt_reg;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_reg <= 2'h0;
            reading_tick <= 1'b0;
        end
        else
        begin
            cnt_reg <= en ? cnt_reg + 2'h1 : 2'h0;
            reading_tick <= en && cnt_reg == 2'h3;
        end
    end
endmodule : acfg_tick_src

// ---- tb/acfg_bank_tb_top.sv ----
// self-checking bench for the configuration bank
`timescale 1ns/1ns
module acfg_bank_tb_top;
    import acfg_pkg::*;
    localparam logic [3:0] ID = 4'ha; // arbitrary value
    logic sys_clk = 0, reset_n = 0, reg_wr_en = 0, reg_rd_en = 0, tick_en = 0;
    logic [3:0] reg_addr = 4'h0;
    acfg_byte_t reg_wr_data = 8'h00, reg_rd_data;
    logic reg_rd_valid, reading_tick, data_valid, pipeline_restart, sync_continuous, high_res_mode;
    logic fir_min_phase, hp_filter_en, lp_filter_en, amp_chopping_en, offset_inject_en, reserved_code;
    logic [2:0] rate_sel, input_route_sel, gain_sel, offset_shift;
    logic [1:0] filter_chain_sel, offset_sel;
    logic [12:0] rate_sps;
    logic [6:0] gain_value, offset_mv;
    logic [15:0] hp_corner;
    int num_errors = 0, n_compared = 0, ticks = 0;
    acfg_bank #(.IDENT_CODE(ID)) u_dut (.*);
    acfg_tick_src u_src (.sys_clk, .reset_n, .en(tick_en), .reading_tick);
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (reading_tick) ticks++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input acfg_byte_t d);
        @(posedge sys_clk) #1;
        reg_wr_en = 1;
        reg_addr = a;
        reg_wr_data = d;
        @(posedge sys_clk) #1;
        reg_wr_en = 0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input acfg_byte_t e);
        @(posedge sys_clk) #1;
        reg_rd_en = 1;
        reg_addr = a;
        @(posedge sys_clk) #1;
        reg_rd_en = 0;
        chk(reg_rd_valid, 1'b1);
        chk(reg_rd_data, e);
    endtask : rd
    task automatic gap(input logic [3:0] a, input acfg_byte_t d, input int stop);
        tick_en = 0;
        wr(a, d);
        ticks = 0;
        tick_en = 1;
        chk(data_valid, 1'b0);
        for (int i = 0; i < 400 && data_valid !== 1'b1 && ticks < stop; i++) @(posedge sys_clk) #1;
    endtask : gap
    task automatic wrap_up();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial
    begin
        #2000000;
        num_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1;
        rd(4'h0, {ID, 4'h0});
        rd(4'h1, 8'h52);
        rd(4'h2, 8'h08);
        rd(4'h3, 8'h32);
        rd(4'h4, 8'h03);
        chk({sync_continuous, high_res_mode, fir_min_phase, amp_chopping_en}, 4'h5);
        chk(rate_sps, 13'h3e8);
        for (int i = 0; i < 8; i++)
        begin
            wr(4'h0, {4'hf, 2'h3, i[1:0]});
            rd(4'h0, {ID, 2'h0, i[1:0]});
            chk({offset_inject_en, offset_mv}, i[1:0] == 2 ? 8'he4 : i[1:0] == 3 ? 8'hcb : 8'h00);
            wr(4'h1, {i[0], ~i[0], i[2:0], i[0], i[1:0]});
            chk({sync_continuous, high_res_mode, fir_min_phase}, {i[0], ~i[0], i[0]});
            chk(rate_sps, i < 5 ? 13'h0fa << i : 13'h0);
            chk({hp_filter_en, lp_filter_en}, {i[1:0] == 2'h3, i[1]});
            wr(4'h2, {1'b1, i[2:0], i[0], i[2:0]});
            rd(4'h2, {1'b0, i[2:0], i[0], i[2:0]});
            chk({input_route_sel, amp_chopping_en}, {i[2:0], i[0]});
            chk(gain_value, i < 7 ? 7'h1 << i : 7'h0);
            chk(offset_shift, i[2:0]);
            chk({rate_sel, filter_chain_sel, gain_sel, offset_sel}, {i[2:0], i[1:0], i[2:0], i[1:0]});
            chk(reserved_code, i > 4 || i[1:0] < 2);
        end
        gap(4'h1, 8'h52, 30);
        gap(4'h3, 8'h5a, 999);
        chk(ticks, 63);
        chk(data_valid, 1'b1);
        chk(hp_corner, 16'h035a);
        wr(4'h5, 8'hff);
        chk(data_valid, 1'b1);
        rd(4'h5, 8'h00);
        rd(4'h3, 8'h5a);
        reset_n = 0;
        #300 reset_n = 1;
        rd(4'h3, 8'h32);
        wrap_up();
    end
endmodule : acfg_bank_tb_top
